// File: rtl/l2ecc_pkg.sv
// package of constants and carrier types for the level-2 memory error protection block
package l2ecc_pkg;

  // =====================================================
  // geometry
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned CHECK_W  = 7;
  localparam int unsigned CODE_W   = DATA_W + CHECK_W;
  localparam int unsigned BANKS    = 4;
  localparam int unsigned BANK_AW  = 2;
  localparam int unsigned WORD_AW  = 8;
  localparam int unsigned ADDR_W   = BANK_AW + WORD_AW;
  localparam int unsigned DEPTH    = 1 << WORD_AW;
  localparam int unsigned STRB_W   = DATA_W / 8;

  // =====================================================
  // reset values
  localparam logic [BANKS-1:0] BYPASS_RST = 4'h0;
  localparam logic             DED_EN_RST = 1'b1;

  // =====================================================
  // carriers and sequencer state type
  typedef struct packed {
    logic                 wr;
    logic [ADDR_W-1:0]    addr;
    logic [STRB_W-1:0]    strb;
    logic [DATA_W-1:0]    wdata;
  } l2ecc_req_t;

  typedef struct packed {
    logic                 valid;
    logic [DATA_W-1:0]    rdata;
    logic                 sec;
    logic                 ded;
  } l2ecc_rsp_t;

  typedef enum logic [1:0] {
    L2ECC_IDLE,
    L2ECC_READ,
    L2ECC_MERGE
  } l2ecc_state_t;

endpackage

// File: rtl/l2ecc_top.sv
// secded protected level-2 memory with per-bank bypass and double-error event
// Function
// RULE1 - store every word with secded check bits
// RULE2 - protection active on all banks after reset
// RULE3 - per-bank control switches protection off alone
// RULE4 - single flipped bit returned corrected, transparently
// RULE5 - double error raises event when reporting enabled; code does so on reads only, not in write merges
// RULE6 - byte and halfword access keep whole-word check
// RULE7 - unprotected bank passes data, no error flags
`timescale 1ns/1ps
module l2ecc_top (
  // clock and reset
  input  wire logic                           core_clk_in,
  input  wire logic                           reset_n_in,
  // requester side
  input  wire logic                           req_valid_in,
  input  wire l2ecc_pkg::l2ecc_req_t          req_in,
  output logic                                req_ready_out,
  output l2ecc_pkg::l2ecc_rsp_t               rsp_out,
  // control levels
  input  wire logic [l2ecc_pkg::BANKS-1:0]    bank_bypass_in,
  input  wire logic                           ded_report_en_in,
  // events
  output logic                                ded_event_out,
  output logic                                sec_event_out
);

  // =====================================================
  // code functions
  // hamming positions 1..38 hold data/check, bit 0 of check word is overall parity
  function automatic logic [l2ecc_pkg::CODE_W-1:0] f_encode(
    input logic [l2ecc_pkg::DATA_W-1:0] d);
    logic [l2ecc_pkg::CODE_W-1:0] cw;
    int unsigned                  di;
    cw = '0;
    di = 0;
    for (int p = 1; p < l2ecc_pkg::CODE_W; p++) begin
      if ((p & (p - 1)) != 0) begin
        cw[p] = d[di];
        di++;
      end
    end
    for (int k = 0; k < 6; k++) begin
      for (int p = 1; p < l2ecc_pkg::CODE_W; p++) begin
        if (((p >> k) & 1) == 1 && p != (1 << k)) begin
          cw[1 << k] = cw[1 << k] ^ cw[p];
        end
      end
    end
    cw[0] = ^cw[l2ecc_pkg::CODE_W-1:1];
    return cw;
  endfunction

  function automatic logic [l2ecc_pkg::DATA_W-1:0] f_extract(
    input logic [l2ecc_pkg::CODE_W-1:0] cw);
    logic [l2ecc_pkg::DATA_W-1:0] d;
    int unsigned                  di;
    d  = '0;
    di = 0;
    for (int p = 1; p < l2ecc_pkg::CODE_W; p++) begin
      if ((p & (p - 1)) != 0) begin
        d[di] = cw[p];
        di++;
      end
    end
    return d;
  endfunction

  function automatic logic [5:0] f_syndrome(input logic [l2ecc_pkg::CODE_W-1:0] cw);
    logic [5:0] s;
    s = '0;
    for (int p = 1; p < l2ecc_pkg::CODE_W; p++) begin
      if (cw[p]) begin
        s = s ^ 6'(p);
      end
    end
    return s;
  endfunction

  function automatic logic [l2ecc_pkg::DATA_W-1:0] f_merge(
    input logic [l2ecc_pkg::DATA_W-1:0] old_d,
    input logic [l2ecc_pkg::DATA_W-1:0] new_d,
    input logic [l2ecc_pkg::STRB_W-1:0] strb);
    logic [l2ecc_pkg::DATA_W-1:0] m;
    m = old_d;
    for (int b = 0; b < l2ecc_pkg::STRB_W; b++) begin
      if (strb[b]) begin
        m[b*8 +: 8] = new_d[b*8 +: 8];
      end
    end
    return m;
  endfunction

  // =====================================================
  // storage
  logic [l2ecc_pkg::CODE_W-1:0] mem_q [l2ecc_pkg::DEPTH*l2ecc_pkg::BANKS];

  // =====================================================
  // state
  l2ecc_pkg::l2ecc_state_t      state_q, state_d;
  l2ecc_pkg::l2ecc_req_t        hold_q, hold_d;
  logic [l2ecc_pkg::CODE_W-1:0] rd_q, rd_d;
  logic                         ready_q, ready_d;
  l2ecc_pkg::l2ecc_rsp_t        rsp_q, rsp_d;
  logic                         ded_q, ded_d;
  logic                         sec_q, sec_d;
  logic                         mem_we;
  logic [l2ecc_pkg::CODE_W-1:0] mem_wd;

  // =====================================================
  // decode of the fetched word
  logic [5:0]                   syn;
  logic                         par_err;
  logic [l2ecc_pkg::CODE_W-1:0] fixed_cw;
  logic                         hold_byp;
  logic                         err_single;
  logic                         err_double;
  logic [l2ecc_pkg::DATA_W-1:0] good_data;

  always_comb begin
    hold_byp   = bank_bypass_in[hold_q.addr[l2ecc_pkg::ADDR_W-1 -: l2ecc_pkg::BANK_AW]]; // RULE3
    syn        = f_syndrome(rd_q);
    par_err    = ^rd_q;
    fixed_cw   = rd_q;
    if (par_err && syn < 6'(l2ecc_pkg::CODE_W)) begin
      fixed_cw[syn] = ~rd_q[syn]; // RULE4
    end
    err_single = !hold_byp && par_err; // RULE2
    err_double = !hold_byp && !par_err && (syn != 6'h00);
    // bypassed bank returns the raw stored bits
    good_data  = hold_byp ? f_extract(rd_q) : f_extract(fixed_cw); // RULE7
  end

  // =====================================================
  // sequencer: read, then merge/write back or answer
  always_comb begin
    state_d = state_q;
    hold_d  = hold_q;
    rd_d    = rd_q;
    ready_d = ready_q;
    rsp_d   = '0;
    ded_d   = 1'b0;
    sec_d   = 1'b0;
    mem_we  = 1'b0;
    mem_wd  = '0;
    case (state_q)
      l2ecc_pkg::L2ECC_IDLE: begin
        ready_d = 1'b1;
        if (req_valid_in && ready_q) begin
          hold_d  = req_in;
          ready_d = 1'b0;
          rd_d    = mem_q[req_in.addr];
          state_d = l2ecc_pkg::L2ECC_READ;
        end
      end
      l2ecc_pkg::L2ECC_READ: begin
        if (hold_q.wr) begin
          state_d = l2ecc_pkg::L2ECC_MERGE;
        end else begin
          rsp_d.valid = 1'b1;
          rsp_d.rdata = good_data; // RULE4
          rsp_d.sec   = err_single; // RULE7
          rsp_d.ded   = err_double;
          ded_d       = err_double && ded_report_en_in; // RULE5
          sec_d       = err_single;
          ready_d     = 1'b1;
          state_d     = l2ecc_pkg::L2ECC_IDLE;
        end
      end
      l2ecc_pkg::L2ECC_MERGE: begin
        // partial write merges into old word, corrected unless its bank is bypassed, whole word re-encoded
        mem_we      = 1'b1;
        mem_wd      = f_encode(f_merge(good_data, hold_q.wdata, hold_q.strb)); // RULE6 RULE1
        rsp_d.valid = 1'b1;
        ready_d     = 1'b1;
        state_d     = l2ecc_pkg::L2ECC_IDLE;
      end
      default: begin
        state_d = l2ecc_pkg::L2ECC_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q <= l2ecc_pkg::L2ECC_IDLE;
      hold_q  <= '0;
      rd_q    <= '0;
      ready_q <= 1'b0;
      rsp_q   <= '0;
      ded_q   <= 1'b0;
      sec_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      hold_q  <= hold_d;
      rd_q    <= rd_d;
      ready_q <= ready_d;
      rsp_q   <= rsp_d;
      ded_q   <= ded_d;
      sec_q   <= sec_d;
    end
  end

  // plain always: the bench injects upsets straight into the array, a second writer
  always @(posedge core_clk_in) begin
    if (mem_we) begin
      mem_q[hold_q.addr] <= mem_wd;
    end
  end

  assign req_ready_out = ready_q;
  assign rsp_out       = rsp_q;
  assign ded_event_out = ded_q;
  assign sec_event_out = sec_q;

  // =====================================================
  // checks
  sequence s_read_taken;
    req_valid_in && req_ready_out && !req_in.wr;
  endsequence

  property p_read_answer;
    @(posedge core_clk_in) disable iff (!reset_n_in)
      s_read_taken |-> ##2 rsp_out.valid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered"); // RULE4

  property p_ded_gate;
    @(posedge core_clk_in) disable iff (!reset_n_in)
      ded_event_out |-> rsp_out.ded && $past(ded_report_en_in);
  endproperty
  a_ded_gate: assert property (p_ded_gate) else $error("double event without cause"); // RULE5

  property p_ded_fire;
    @(posedge core_clk_in) disable iff (!reset_n_in)
      (rsp_out.ded && $past(ded_report_en_in)) |-> ded_event_out;
  endproperty
  a_ded_fire: assert property (p_ded_fire) else $error("double error not reported"); // RULE5

  property p_bypass_quiet;
    @(posedge core_clk_in) disable iff (!reset_n_in)
      (state_q == l2ecc_pkg::L2ECC_READ && !hold_q.wr && hold_byp)
        |=> !rsp_out.sec && !rsp_out.ded && !ded_event_out;
  endproperty
  a_bypass_quiet: assert property (p_bypass_quiet) else $error("bypass flagged error"); // RULE7

  property p_encode_clean;
    @(posedge core_clk_in) disable iff (!reset_n_in)
      mem_we |-> (f_syndrome(mem_wd) == 6'h00) && !(^mem_wd);
  endproperty
  a_encode_clean: assert property (p_encode_clean) else $error("written word not clean"); // RULE1

  property p_single_not_double;
    @(posedge core_clk_in) disable iff (!reset_n_in)
      rsp_out.valid |-> !(rsp_out.sec && rsp_out.ded);
  endproperty
  a_single_not_double: assert property (p_single_not_double) else $error("sec with ded"); // RULE4

  sequence s_write_taken;
    req_valid_in && req_ready_out && req_in.wr;
  endsequence

  property p_write_done;
    @(posedge core_clk_in) disable iff (!reset_n_in)
      s_write_taken |-> ##1 !req_ready_out
        ##2 mem_q[hold_q.addr] == $past(mem_wd);
  endproperty
  a_write_done: assert property (p_write_done) else $error("write not stored"); // RULE6

  property p_default_on;
    @(posedge core_clk_in) disable iff (!reset_n_in)
      (state_q == l2ecc_pkg::L2ECC_READ && bank_bypass_in == l2ecc_pkg::BYPASS_RST && par_err)
        |-> err_single;
  endproperty
  a_default_on: assert property (p_default_on) else $error("protection not active"); // RULE2

endmodule

// File: tb/l2ecc_master.sv
// requester model: one transfer at a time on the request handshake
`timescale 1ns/1ps
module l2ecc_master (
  // clock
  input  wire logic             core_clk_in,
  // request handshake
  output logic                  req_valid_out,
  output l2ecc_pkg::l2ecc_req_t req_out,
  input  wire logic             req_ready_in
);
  // ==========================================
  // called at edge+1; holds until taken, stalls, then waits for idle
  task automatic xfer(input l2ecc_pkg::l2ecc_req_t r, input int gap);
    int n;
    req_valid_out = 1'b1;
    req_out       = r;
    for (n = 0; n < 50 && req_ready_in !== 1'b1; n++) begin
      @(posedge core_clk_in);
      #1;
    end
    @(posedge core_clk_in);
    #1;
    req_valid_out = 1'b0;
    req_out       = ~r;
    for (n = 0; n < gap + 50 && (n < gap || req_ready_in !== 1'b1); n++) begin
      @(posedge core_clk_in);
      #1;
    end
  endtask

  initial begin
    req_valid_out = 1'b0;
    req_out       = '0;
  end
endmodule

// File: tb/l2ecc_tb_top.sv
// self-checking bench for the protected level-2 memory
`timescale 1ns/1ps
module l2ecc_tb_top;
  typedef struct packed {
    logic        rd;
    logic        dchk;
    logic [31:0] data;
    logic        sec;
    logic        ded;
    logic        dev;
  } l2ecc_exp_t;
  logic                  core_clk_in;
  logic                  reset_n_in;
  logic                  req_valid;
  l2ecc_pkg::l2ecc_req_t req;
  logic                  req_ready;
  l2ecc_pkg::l2ecc_rsp_t rsp;
  logic [3:0]            bypass;
  logic                  ded_en;
  logic                  ded_ev;
  logic                  sec_ev;
  logic [31:0]           ref_mem [0:1023];
  logic [9:0]            a;
  l2ecc_exp_t            exp_q [$];
  l2ecc_exp_t            e;
  int                    err_count;
  int                    check_count;
  int                    cycles;
  int                    b;
  int                    p;

  l2ecc_top uut (
    .core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .req_valid_in(req_valid),
    .req_in(req), .req_ready_out(req_ready), .rsp_out(rsp), .bank_bypass_in(bypass),
    .ded_report_en_in(ded_en), .ded_event_out(ded_ev), .sec_event_out(sec_ev));
  l2ecc_master m_req (
    .core_clk_in(core_clk_in), .req_valid_out(req_valid), .req_out(req),
    .req_ready_in(req_ready));

  always #5 core_clk_in = ~core_clk_in;

  // ==========================================
  // tasks
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic wr(input logic [9:0] ad, input logic [3:0] s, input logic [31:0] d);
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        ref_mem[ad][8*i+:8] = d[8*i+:8];
      end
    end
    exp_q.push_back('0);
    m_req.xfer('{1'b1, ad, s, d}, $urandom_range(2, 0));
  endtask

  task automatic rd(input logic [9:0] ad, input logic s, input logic d, input logic dc);
    exp_q.push_back('{1'b1, dc, ref_mem[ad], s, d, d & ded_en});
    m_req.xfer('{1'b0, ad, 4'h0, 32'($urandom)}, $urandom_range(2, 0));
  endtask

  // upsets injected straight into the stored code word
  // one edge first, so the write-back check still sees the clean stored word
  task automatic flip(input logic [9:0] ad, input int p1, input int p2);
    @(posedge core_clk_in);
    #1;
    uut.mem_q[ad] = uut.mem_q[ad] ^ ((39'h1 << p1) | (39'h1 << p2));
  endtask

  // ==========================================
  // response watcher
  always @(posedge core_clk_in) begin
    #1;
    if (rsp.valid === 1'b1) begin
      e = exp_q.pop_front();
      check("ready", req_ready, 1'b1);
      if (e.rd) begin
        if (e.dchk) check("rdata", rsp.rdata, e.data);
        check("sec", rsp.sec, e.sec);
        check("ded", rsp.ded, e.ded);
        check("sec_event", sec_ev, e.sec);
        check("ded_event", ded_ev, e.dev);
      end else begin
        check("wr_flags", 32'({rsp.sec, rsp.ded, sec_ev, ded_ev}), 32'h0);
      end
    end
  end

  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      conclude();
    end
  end

  // ==========================================
  // main sequence
  initial begin
    core_clk_in = 1'b0;
    reset_n_in  = 1'b0;
    bypass      = 4'h0;
    ded_en      = 1'b1;
    err_count   = 0;
    check_count = 0;
    cycles      = 0;
    void'($urandom(62090));
    repeat (2) @(posedge core_clk_in);
    #1;
    reset_n_in = 1'b1;
    @(posedge core_clk_in);
    #1;
    // corrected bit in every bank straight out of reset
    for (b = 0; b < 4; b++) begin
      a = {b[1:0], 8'h00};
      wr(a, 4'hf, $urandom);
      p = $urandom_range(38, 0);
      flip(a, p, p);
      rd(a, 1'b1, 1'b0, 1'b1);
    end
    // every lane mask, then a corrected bit in the merged word
    for (b = 0; b < 16; b++) begin
      a = {b[1:0], 8'h10 + 8'(b)};
      wr(a, 4'hf, $urandom);
      wr(a, b[3:0], $urandom);
      p = $urandom_range(38, 0);
      flip(a, p, p);
      rd(a, 1'b1, 1'b0, 1'b1);
    end
    // double error with reporting off then on
    for (b = 0; b < 2; b++) begin
      ded_en = b[0];
      a = {2'h2, 8'h30 + 8'(b)};
      wr(a, 4'hf, $urandom);
      p = $urandom_range(38, 0);
      flip(a, p, (p + 1 + $urandom_range(37, 0)) % 39);
      rd(a, 1'b0, 1'b1, 1'b0);
    end
    // bank 1 unprotected, bank 0 still corrects
    bypass = 4'h2;
    for (b = 0; b < 2; b++) begin
      a = {b[1:0], 8'h40};
      wr(a, 4'hf, $urandom);
      rd(a, 1'b0, 1'b0, 1'b1);
      p = $urandom_range(38, 0);
      flip(a, p, p);
      rd(a, b == 0, 1'b0, b == 0);
      if (b == 1) begin
        flip(a, (p + 1) % 39, (p + 1) % 39);
        rd(a, 1'b0, 1'b0, 1'b0);
      end
    end
    bypass = 4'h0;
    repeat (5) @(posedge core_clk_in);
    check("pending", exp_q.size(), 32'h0);
    conclude();
  end
endmodule
